//--- tb/spc_checker.sv
// checker: port-level assertions for the scan program control block
`timescale 1ns/1ps
module spc_checker #(
    parameter int WDT_DEF_CYC = spc_pkg::WDT_DEF_MS * spc_pkg::CYC_PER_MS,
    parameter int ADDR_W      = 16
) (
    // apb
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [31:0]       prdata,
    // instruction stream and status
    input wire logic [ADDR_W-1:0] instr_addr,
    input wire logic [ADDR_W-1:0] jump_addr,
    input wire logic              jump_valid,
    input wire logic              program_mode_flag,
    input wire logic              terminal_program_mode_flag,
    input wire logic              io_update_hold,
    input wire logic              rail_power
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire ins_wr = psel && penable && pwrite && paddr == spc_pkg::ADDR_INSTR;
    wire halt_wr = ins_wr && pready && pwdata[3:0] == spc_pkg::OP_HALT;
    wire running = !program_mode_flag && !terminal_program_mode_flag;
    property p_setup; psel && !penable |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    property p_err; pslverr |-> pready && psel && penable; endproperty
    property p_rdata; prdata != 32'h0 |-> pready && !pwrite; endproperty
    property p_jpulse; jump_valid |=> !jump_valid; endproperty
    property p_jsrc; jump_valid |-> $past(ins_wr); endproperty
    property p_jrun; jump_valid |-> !$past(program_mode_flag); endproperty
    property p_halt; halt_wr && running |-> ##[1:3] program_mode_flag;
    endproperty
    a_setup: assert property (p_setup) else $error("late ready");
    a_pulse: assert property (p_pulse) else $error("long ready");
    a_err: assert property (p_err) else $error("stray slverr");
    a_rdata: assert property (p_rdata) else $error("stray rdata");
    a_jpulse: assert property (p_jpulse) else $error("long jump");
    a_jsrc: assert property (p_jsrc) else $error("jump w/o instr");
    a_jrun: assert property (p_jrun) else $error("jump stopped");
    a_halt: assert property (p_halt) else $error("halt ignored");
    c_jump: cover property (jump_valid);
    c_hold: cover property ($rose(io_update_hold));
    c_halt: cover property (halt_wr && running);
endmodule
bind spc_program_control spc_checker #(
    .WDT_DEF_CYC(WDT_DEF_CYC),
    .ADDR_W     (ADDR_W)
) i_spc_checker (.*);

//--- tb/tb_spc_program_control.sv
// testbench: scan program control driven over apb
`timescale 1ns/1ps
module tb_spc_program_control;
    typedef struct {logic [31:0] m; logic [31:0] v; logic e;} spc_exp_s;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] instr_addr = 16'h0, jump_addr, la, k;
    logic pready, pslverr, jump_valid, prg, tprg, hold, rail;
    int failures = 0, cmp_count = 0, cyc = 0;
    spc_exp_s rq[$], jq[$], x;
    spc_program_control #(.WDT_DEF_CYC(200), .ADDR_W(16))
    i_spc_program_control (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .instr_addr(instr_addr), .jump_addr(jump_addr),
        .jump_valid(jump_valid), .program_mode_flag(prg),
        .terminal_program_mode_flag(tprg), .io_update_hold(hold),
        .rail_power(rail));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        chk("jump_left", 32'h0, 32'(jq.size()));
        chk("read_left", 32'h0, 32'(rq.size()));
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] m, v, logic e = 0);
        rq.push_back('{m, v, e});
        apb(0, a, 32'h0);
    endtask
    task automatic ins(logic [15:0] a, logic [4:0] op, logic [15:0] c);
        apb(1, spc_pkg::ADDR_OPERAND, {16'h0, c});
        instr_addr <= a;
        apb(1, spc_pkg::ADDR_INSTR, {27'h0, op});
    endtask
    task automatic run; apb(1, 8'h00, 32'h4); apb(1, 8'h00, 32'h1); endtask
    task automatic flag(string n, logic e, ref logic g);
        repeat (3) @(posedge pclk);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    // ------------------------------------------------------------
    // clock, monitors, timeout
    // ------------------------------------------------------------
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        if (pready === 1'b1 && pwrite === 1'b0) begin
            x = rq.pop_front();
            chk("prdata", x.v & x.m, prdata & x.m);
            chk("pslverr", {31'h0, x.e}, {31'h0, pslverr});
        end
        if (jump_valid === 1'b1) begin
            if (jq.size() == 0) chk("jump", 32'h0, 32'h1);
            else begin
                x = jq.pop_front();
                chk("jump_addr", x.v & x.m, {16'h0, jump_addr} & x.m);
            end
        end
        if (++cyc == 30000) begin
            failures++;
            wrap_up();
        end
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hC19D));
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(8'h04, 32'h86, 32'h82);
        rd(8'h40, 32'hFFFFFFFF, 32'h0, 1);
        apb(1, 8'h00, 32'h2);
        flag("term", 1, tprg);
        run();
        flag("prg", 0, prg);
        $display("modes done");
        k = 16'($urandom_range(1, 16'hFFFF));
        la = 16'($urandom);
        ins(la, 5'h06, k);
        jq.push_back('{32'hFFFF, {16'h0, la}, 0});
        ins(16'h0100, 5'h15, k);
        rd(8'h20, 32'hF, 32'h1);
        jq.push_back('{32'hFFFF, 32'h0101, 0});
        ins(16'h0500, 5'h07, 16'h0);
        rd(8'h20, 32'hF, 32'h0);
        jq.push_back('{32'hFFFF, {16'h0, la}, 0});
        ins(16'h0100, 5'h15, k);
        ins(16'h0502, 5'h08, 16'h0);
        rd(8'h20, 32'hF, 32'h1);
        jq.push_back('{32'hFFFF, 32'h0101, 0});
        ins(16'h0504, 5'h18, 16'h0);
        $display("calls done");
        ins(16'h0200, 5'h13, 16'h2);
        flag("hold", 1, hold);
        jq.push_back('{32'hFFFF, 32'h0201, 0});
        ins(16'h0208, 5'h04, 16'h0);
        ins(16'h0208, 5'h04, 16'h0);
        flag("hold", 0, hold);
        ins(16'h0300, 5'h03, 16'h5);
        rd(8'h04, 32'h160, 32'h100);
        ins(16'h0308, 5'h04, 16'h0);
        ins(16'h0400, 5'h09, 16'h1);
        flag("rail", 0, rail);
        ins(16'h0404, 5'h0A, 16'h0);
        flag("rail", 1, rail);
        ins(16'h0408, 5'h19, 16'h1);
        flag("rail", 1, rail);
        ins(16'h040C, 5'h0A, 16'h0);
        $display("loops and rails done");
        apb(1, 8'h00, 32'h9);
        repeat (3) begin
            repeat (150) @(posedge pclk);
            ins(16'h0, 5'h02, 16'h0);
        end
        flag("prg", 0, prg);
        apb(1, 8'h08, 32'd400);
        rd(8'h08, 32'hFFFFFFFF, 32'd400);
        repeat (300) @(posedge pclk);
        flag("prg", 0, prg);
        repeat (150) @(posedge pclk);
        flag("prg", 1, prg);
        rd(8'h20, 32'hFFFF0000, 32'h00030000);
        $display("watchdog done");
        run();
        ins(la, 5'h06, k);
        repeat (8) begin
            jq.push_back('{32'hFFFF, {16'h0, la}, 0});
            ins(16'($urandom), 5'h15, k);
        end
        ins(16'h0600, 5'h15, k);
        flag("prg", 1, prg);
        rd(8'h20, 32'hFFFF0000, 32'h04120000);
        run();
        ins(16'h0700, 5'h01, 16'h0);
        flag("prg", 1, prg);
        ins(16'h0, 5'h0B, 16'h0);
        rd(8'h20, 32'h3FF0, 32'h0);
        $display("nesting and halt done");
        wrap_up();
    end
endmodule

//--- verilog/spc_pkg.sv
// package: constants for the scan program control block
package spc_pkg;

    // ------------------------------------------------------------
    // apb register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_WDT_SET  = 8'h08;
    localparam logic [7:0] ADDR_WDT_CNT  = 8'h0C;
    localparam logic [7:0] ADDR_INSTR    = 8'h10;
    localparam logic [7:0] ADDR_OPERAND  = 8'h14;
    localparam logic [7:0] ADDR_LOOP     = 8'h18;
    localparam logic [7:0] ADDR_RAIL     = 8'h1C;
    localparam logic [7:0] ADDR_SUBR     = 8'h20;
    localparam logic [7:0] ADDR_RET_ADDR = 8'h24;

    // ------------------------------------------------------------
    // control register bits
    // ------------------------------------------------------------
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_TERMINAL_PROGRAM_MODE = 1;
    localparam int CTRL_ERR_CLR  = 2;
    localparam int CTRL_SCAN_END = 3;

    // ------------------------------------------------------------
    // status register bits
    // ------------------------------------------------------------
    localparam int ST_RUN       = 0;
    localparam int ST_PRG       = 1;
    localparam int ST_TERMINAL_PROGRAM_MODE  = 2;
    localparam int ST_TIMEOUT   = 3;
    localparam int ST_SUB_ERR   = 4;
    localparam int ST_IN_LOOP   = 5;
    localparam int ST_IO_HOLD   = 6;
    localparam int ST_RAIL_PWR  = 7;
    localparam int ST_SKIP      = 8;

    // ------------------------------------------------------------
    // instruction opcodes (instruction register low bits)
    // ------------------------------------------------------------
    localparam logic [3:0] OP_NONE      = 4'h0;
    localparam logic [3:0] OP_HALT      = 4'h1;
    localparam logic [3:0] OP_WDT_RST   = 4'h2;
    localparam logic [3:0] OP_LOOP_BEG  = 4'h3;
    localparam logic [3:0] OP_LOOP_END  = 4'h4;
    localparam logic [3:0] OP_CALL      = 4'h5;
    localparam logic [3:0] OP_LABEL     = 4'h6;
    localparam logic [3:0] OP_RET       = 4'h7;
    localparam logic [3:0] OP_RET_COND  = 4'h8;
    localparam logic [3:0] OP_RAIL_SET  = 4'h9;
    localparam logic [3:0] OP_RAIL_CLR  = 4'hA;
    localparam logic [3:0] OP_PROG_CLR  = 4'hB;
    localparam int         INSTR_COND   = 4;

    // ------------------------------------------------------------
    // limits and timing
    // ------------------------------------------------------------
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          WDT_DEF_MS    = 200;
    localparam int          CYC_PER_MS    = CLK_HZ / 1000;
    localparam logic [15:0] LOOP_MAX      = 16'd9999;
    localparam logic [15:0] LOOP_MIN      = 16'd1;
    localparam int          CALL_MAX      = 64;
    localparam int          LABEL_MAX     = 64;
    localparam int          NEST_MAX      = 8;
    localparam int          RAIL_LEVELS   = 7;
    localparam logic [15:0] ERR_TIMEOUT   = 16'h0003;
    localparam logic [15:0] ERR_SUB_LIMIT = 16'h0412;

    typedef enum logic [1:0] {
        SPC_RUN,
        SPC_PRG,
        SPC_TERMINAL_PROGRAM_MODE
    } spc_mode_e;

endpackage

//--- verilog/spc_program_control.sv
// module: program control unit of a ladder-executing controller cpu
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
module spc_program_control #(
    parameter int WDT_DEF_CYC = spc_pkg::WDT_DEF_MS * spc_pkg::CYC_PER_MS,
    parameter int ADDR_W      = 16
) (
    // apb clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    // instruction stream
    input  wire logic [ADDR_W-1:0] instr_addr,
    output logic [ADDR_W-1:0]      jump_addr,
    output logic                   jump_valid,
    // status outputs
    output logic                   program_mode_flag,
    output logic                   terminal_program_mode_flag,
    output logic                   io_update_hold,
    output logic                   rail_power
);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic        wr_acc;
    logic        rd_acc;
    logic        addr_ok;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;

    function automatic logic mapped(input logic [7:0] a);
        case (a)
            spc_pkg::ADDR_CTRL, spc_pkg::ADDR_STATUS,
            spc_pkg::ADDR_WDT_SET, spc_pkg::ADDR_WDT_CNT,
            spc_pkg::ADDR_INSTR, spc_pkg::ADDR_OPERAND,
            spc_pkg::ADDR_LOOP, spc_pkg::ADDR_RAIL,
            spc_pkg::ADDR_SUBR, spc_pkg::ADDR_RET_ADDR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction
    assign addr_ok = mapped(paddr);

    // instruction issue: operand first, then opcode write executes
    logic        exec;
    logic [3:0]  opc;
    logic        cond;
    logic [15:0] operand;
    assign exec = wr_acc && (paddr == spc_pkg::ADDR_INSTR);
    assign opc  = pwdata[3:0];
    assign cond = pwdata[spc_pkg::INSTR_COND];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    spc_pkg::spc_mode_e mode;
    logic [31:0]        wdt_set;
    logic [31:0]        wdt_cnt;
    logic               err_timeout;
    logic               err_sub;
    logic [15:0]        err_code;
    logic               in_loop;
    logic               loop_skip;
    logic [15:0]        loop_left;
    logic [ADDR_W-1:0]  loop_top;
    logic [2:0]         rail_lvl;
    logic [7:0]         rail_cond;
    logic [6:0]         call_cnt;
    logic [6:0]         label_cnt;
    logic [3:0]         sp;
    logic [ADDR_W-1:0]  ret_stack [spc_pkg::NEST_MAX];
    logic [ADDR_W-1:0]  label_addr [spc_pkg::LABEL_MAX];
    logic [15:0]        label_key [spc_pkg::LABEL_MAX];
    logic [spc_pkg::LABEL_MAX-1:0] label_vld;
    logic               running;
    logic               timeout_hit;
    logic               sub_over;
    logic               call_found;
    logic [ADDR_W-1:0]  call_dest;

    assign running = (mode == spc_pkg::SPC_RUN);
    assign timeout_hit = running && (wdt_cnt >= wdt_set);

    // label lookup for a call constant
    always_comb begin
        call_found = 1'b0;
        call_dest  = '0;
        for (int i = 0; i < spc_pkg::LABEL_MAX; i++) begin
            if (label_vld[i] && label_key[i] == operand) begin
                call_found = 1'b1;
                call_dest  = label_addr[i];
            end
        end
    end

    // call limits: nesting depth and call count
    assign sub_over = exec && running && opc == spc_pkg::OP_CALL &&
                      (sp == 4'(spc_pkg::NEST_MAX) ||
                       call_cnt == 7'(spc_pkg::CALL_MAX));

    // ------------------------------------------------------------
    // operand register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand <= '0;
        end else if (wr_acc && paddr == spc_pkg::ADDR_OPERAND) begin
            operand <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------
    // operating mode
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= spc_pkg::SPC_PRG;
        end else if (running && (timeout_hit || sub_over)) begin
            mode <= spc_pkg::SPC_PRG;
        end else if (exec && running && opc == spc_pkg::OP_HALT) begin
            mode <= spc_pkg::SPC_PRG;
        end else if (wr_acc && paddr == spc_pkg::ADDR_CTRL) begin
            if (pwdata[spc_pkg::CTRL_TERMINAL_PROGRAM_MODE])
                mode <= spc_pkg::SPC_TERMINAL_PROGRAM_MODE;
            else if (pwdata[spc_pkg::CTRL_RUN] && !err_timeout && !err_sub)
                mode <= spc_pkg::SPC_RUN;
            else if (!pwdata[spc_pkg::CTRL_RUN])
                mode <= spc_pkg::SPC_PRG;
        end
    end

    // ------------------------------------------------------------
    // scan watchdog
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_set <= 32'(WDT_DEF_CYC);
        end else if (wr_acc && paddr == spc_pkg::ADDR_WDT_SET &&
                     pwdata >= 32'(WDT_DEF_CYC)) begin
            wdt_set <= pwdata;
        end
    end

    // a new scan or a restart both measure again from zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt <= '0;
        end else if (!running) begin
            wdt_cnt <= '0;
        end else if (exec && opc == spc_pkg::OP_WDT_RST) begin
            wdt_cnt <= '0;
        end else if (wr_acc && paddr == spc_pkg::ADDR_CTRL &&
                     pwdata[spc_pkg::CTRL_SCAN_END]) begin
            wdt_cnt <= '0;
        end else if (!timeout_hit) begin
            wdt_cnt <= wdt_cnt + 32'd1;
        end
    end

    // ------------------------------------------------------------
    // error flags; a new error wins over a clear in the same cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_timeout <= 1'b0;
            err_sub     <= 1'b0;
            err_code    <= '0;
        end else begin
            if (timeout_hit) begin
                err_timeout <= 1'b1;
                err_code    <= spc_pkg::ERR_TIMEOUT;
            end else if (sub_over || (exec && running &&
                         opc == spc_pkg::OP_LABEL &&
                         label_cnt == 7'(spc_pkg::LABEL_MAX))) begin
                err_sub  <= 1'b1;
                err_code <= spc_pkg::ERR_SUB_LIMIT;
            end else if (wr_acc && paddr == spc_pkg::ADDR_CTRL &&
                         pwdata[spc_pkg::CTRL_ERR_CLR]) begin
                err_timeout <= 1'b0;
                err_sub     <= 1'b0;
                err_code    <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // counted loop
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_loop   <= 1'b0;
            loop_skip <= 1'b0;
            loop_left <= '0;
            loop_top  <= '0;
        end else if (!running) begin
            in_loop   <= 1'b0;
            loop_skip <= 1'b0;
        end else if (exec && opc == spc_pkg::OP_LOOP_BEG && !in_loop &&
                     !loop_skip) begin
            // nesting is the program's job; a second start is ignored
            if (cond && operand >= spc_pkg::LOOP_MIN &&
                operand <= spc_pkg::LOOP_MAX) begin
                in_loop   <= 1'b1;
                loop_left <= operand;
                loop_top  <= instr_addr + ADDR_W'(1);
            end else begin
                loop_skip <= 1'b1;
            end
        end else if (exec && opc == spc_pkg::OP_LOOP_END) begin
            loop_skip <= 1'b0;
            if (in_loop) begin
                loop_left <= loop_left - 16'd1;
                if (loop_left == spc_pkg::LOOP_MIN)
                    in_loop <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // subroutine labels, call count, return-address stack
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            label_cnt <= '0;
            label_vld <= '0;
            call_cnt  <= '0;
        end else if (exec && opc == spc_pkg::OP_PROG_CLR) begin
            label_cnt <= '0;
            label_vld <= '0;
            call_cnt  <= '0;
        end else if (exec && running && opc == spc_pkg::OP_LABEL &&
                     label_cnt != 7'(spc_pkg::LABEL_MAX)) begin
            label_key[label_cnt[5:0]]  <= operand;
            label_addr[label_cnt[5:0]] <= instr_addr;
            label_vld[label_cnt[5:0]]  <= 1'b1;
            label_cnt <= label_cnt + 7'd1;
        end else if (exec && running && opc == spc_pkg::OP_CALL &&
                     cond && !sub_over && call_found) begin
            call_cnt <= call_cnt + 7'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp <= '0;
        end else if (!running) begin
            sp <= '0;
        end else if (exec && opc == spc_pkg::OP_CALL && cond &&
                     !sub_over && call_found) begin
            ret_stack[sp[2:0]] <= instr_addr + ADDR_W'(1);
            sp <= sp + 4'd1;
        end else if (exec && sp != 4'd0 &&
                     (opc == spc_pkg::OP_RET ||
                      (opc == spc_pkg::OP_RET_COND && cond))) begin
            sp <= sp - 4'd1;
        end
    end

    // ------------------------------------------------------------
    // jump output toward the instruction fetch
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jump_addr  <= '0;
            jump_valid <= 1'b0;
        end else begin
            jump_valid <= 1'b0;
            if (exec && running) begin
                case (opc)
                    spc_pkg::OP_CALL: begin
                        // subroutines past the end are reached only here
                        if (cond && !sub_over && call_found) begin
                            jump_addr  <= call_dest;
                            jump_valid <= 1'b1;
                        end
                    end
                    spc_pkg::OP_RET, spc_pkg::OP_RET_COND: begin
                        if (sp != 4'd0 &&
                            (opc == spc_pkg::OP_RET || cond)) begin
                            jump_addr  <= ret_stack[sp[2:0] - 3'd1];
                            jump_valid <= 1'b1;
                        end
                    end
                    spc_pkg::OP_LOOP_END: begin
                        if (in_loop && loop_left != spc_pkg::LOOP_MIN) begin
                            jump_addr  <= loop_top;
                            jump_valid <= 1'b1;
                        end
                    end
                    default: jump_valid <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // master rail stack
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rail_lvl  <= '0;
            rail_cond <= 8'h01;
        end else if (!running) begin
            rail_lvl  <= '0;
            rail_cond <= 8'h01;
        end else if (exec && opc == spc_pkg::OP_RAIL_SET &&
                     operand >= 16'd1 &&
                     operand <= 16'(spc_pkg::RAIL_LEVELS)) begin
            rail_lvl <= operand[2:0];
            rail_cond[operand[2:0]] <= cond &&
                                       rail_cond[operand[2:0] - 3'd1];
        end else if (exec && opc == spc_pkg::OP_RAIL_CLR &&
                     operand <= 16'(spc_pkg::RAIL_LEVELS) &&
                     operand[2:0] < rail_lvl) begin
            rail_lvl <= operand[2:0];
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_mode_flag          <= 1'b0;
            terminal_program_mode_flag <= 1'b0;
            io_update_hold             <= 1'b0;
            rail_power                 <= 1'b1;
        end else begin
            program_mode_flag <= (mode == spc_pkg::SPC_PRG);
            terminal_program_mode_flag <=
                (mode == spc_pkg::SPC_TERMINAL_PROGRAM_MODE);
            io_update_hold <= in_loop;
            rail_power     <= rail_cond[rail_lvl] && !loop_skip;
        end
    end

    // ------------------------------------------------------------
    // apb answer: zero wait states, error on unmapped address
    // ------------------------------------------------------------
    function automatic logic [31:0] read_mux(input logic [7:0] a);
        case (a)
            spc_pkg::ADDR_CTRL:    read_mux = {31'h0, running};
            spc_pkg::ADDR_STATUS:  read_mux = {23'h0, loop_skip,
                rail_cond[rail_lvl], in_loop, in_loop, err_sub,
                err_timeout, mode == spc_pkg::SPC_TERMINAL_PROGRAM_MODE,
                mode == spc_pkg::SPC_PRG, running};
            spc_pkg::ADDR_WDT_SET: read_mux = wdt_set;
            spc_pkg::ADDR_WDT_CNT: read_mux = wdt_cnt;
            spc_pkg::ADDR_OPERAND: read_mux = {16'h0, operand};
            spc_pkg::ADDR_LOOP:    read_mux = {16'h0, loop_left};
            spc_pkg::ADDR_RAIL:    read_mux = {21'h0, rail_lvl, rail_cond};
            spc_pkg::ADDR_SUBR:    read_mux = {err_code, 2'h0,
                label_cnt[5:0], call_cnt[3:0], sp};
            spc_pkg::ADDR_RET_ADDR:
                read_mux = 32'(sp == 4'd0 ? '0 : ret_stack[sp[2:0] - 3'd1]);
            default:               read_mux = 32'h0;
        endcase
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            prdata  <= (psel && !penable && !pwrite) ? read_mux(paddr)
                                                     : 32'h0;
        end
    end

endmodule
